// >>> rtl/dong_pkg.sv
// Constants shared by the decoder output noise gate
// What this block does
// - High-pass each low-band sample, coefficient 0.75.
// - Frame energy sums squared high-passed samples.
// - Total energy adds previous frame energy.
// - Previous energy zero at reset, then replaced.
// - Target gain sqrt(total)/128, floor 0.25.
// - Band powers sum absolute sample values.
// - Narrow-band keeps energy-derived target gain.
// - Decoded high-band dominance above the power floor forces target gain 1.0.
// - Smoothed gain updates once per output sample.
// - Smoothed gain starts at 1.0.
// - Wideband samples scaled while gain below 1.0.
// - Narrow-band samples scaled while gain below 1.0.
package dong_pkg;
    // =========================================================
    // Frame geometry
    localparam int FRAME_LEN = 40;
    localparam int WB_LEN    = 80;
    localparam int MEM_DEPTH = 64;
    localparam int MEM_AW    = 6;
    localparam int CNT_W     = 7;
    localparam int SAMPLE_W  = 16;
    localparam int WORD_W    = 48;
    // =========================================================
    // Arithmetic widths; energy is kept as sum of (4z)^2 so it stays exact
    localparam int HP_W      = 19;
    localparam int SQ_W      = 38;
    localparam int EN_W      = 44;
    localparam int ROOT_W    = 22;
    localparam int REM_W     = 24;
    localparam int SQRT_CNT_W = 5;
    localparam int GAIN_W    = 24;
    localparam int PWR_W     = 22;
    localparam int PROD_W    = 64;
    // =========================================================
    // Gains in Q15: 1.0 is 32768
    localparam logic [GAIN_W-1:0] GAIN_ONE     = 24'h008000;
    localparam logic [GAIN_W-1:0] GAIN_QUARTER = 24'h002000;
    localparam logic [GAIN_W-1:0] GAIN_MAX     = 24'hffffff;
    localparam int                GAIN_FRAC    = 15;
    // sqrt(16*Et) * 64 equals sqrt(Et)/2^7 in Q15
    localparam int                GAIN_SQRT_SH = 6;
    // 0.9893 and 0.0107 in Q15, summing to exactly 1.0
    localparam logic [15:0]       COEF_KEEP    = 16'h7ea1;
    localparam logic [15:0]       COEF_TARGET  = 16'h015f;
    // High-band power threshold 800/(2^31-1), samples taken as Q15
    localparam logic [31:0]       HB_PWR_NUM   = 32'h00000320;
    localparam logic [31:0]       HB_PWR_DEN   = 32'h7fffffff;
    localparam int                HB_PWR_Q     = 15;
    localparam int                HB_RATIO_SH  = 4;
    localparam logic [EN_W-1:0]   ENERGY_RST   = 44'h00000000000;
    localparam int                HP_PREV_MUL  = 3;
    localparam int                HP_CUR_SH    = 2;
endpackage

// >>> rtl/dong_frame_mem.sv
// Frame store: one word per input beat, registered read data
`timescale 1ns/1ns
module dong_frame_mem #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  logic             clk_i,
    input  logic             wr_en_i,
    input  logic [AW-1:0]    wr_addr_i,
    input  logic [WIDTH-1:0] wr_data_i,
    input  logic [AW-1:0]    rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rd_data_o <= mem[rd_addr_i];
    end
endmodule // dong_frame_mem

// >>> rtl/dong_noise_gate.sv
// Decoder output noise gate: frame analysis and per-sample gain
`timescale 1ns/1ns
module dong_noise_gate (
    input  logic        clk_i,
    input  logic        rst_n_i,
    input  logic        in_valid_i,
    output logic        in_ready_o,
    input  logic [15:0] lb_i,
    input  logic [15:0] hb_i,
    input  logic [15:0] wb_even_i,
    input  logic [15:0] wb_odd_i,
    input  logic        hb_decoded_i,
    input  logic        wb_output_i,
    output logic        out_valid_o,
    input  logic        out_ready_i,
    output logic [15:0] out_sample_o,
    output logic        out_last_o
);
    // =========================================================
    // State
    typedef enum logic [2:0] {
        S_FILL  = 3'b000,
        S_TOTAL = 3'b001,
        S_SQRT  = 3'b010,
        S_GAIN  = 3'b011,
        S_READ  = 3'b100,
        S_LOAD  = 3'b101,
        S_OUT   = 3'b110
    } dong_state_t;

    dong_state_t                           state;
    logic [dong_pkg::CNT_W-1:0]            cnt;
    logic [dong_pkg::CNT_W-1:0]            out_len;
    logic                                  hb_dec;
    logic                                  wb_mode;
    logic signed [dong_pkg::SAMPLE_W-1:0]  prev_lb;
    logic [dong_pkg::EN_W-1:0]             frame_energy;
    logic [dong_pkg::EN_W-1:0]             prev_energy;
    logic [dong_pkg::PWR_W-1:0]            low_band_power;
    logic [dong_pkg::PWR_W-1:0]            high_band_power;
    logic [dong_pkg::EN_W-1:0]             radicand;
    logic [dong_pkg::REM_W-1:0]            sq_rem;
    logic [dong_pkg::ROOT_W-1:0]           sq_root;
    logic [dong_pkg::SQRT_CNT_W-1:0]       sq_cnt;
    logic [dong_pkg::GAIN_W-1:0]           target_gain;
    logic [dong_pkg::GAIN_W-1:0]           smoothed_gate_gain;
    logic [dong_pkg::WORD_W-1:0]           rd_word;
    logic                                  accept;
    logic                                  frame_done;

    assign in_ready_o = (state == S_FILL);
    assign accept     = in_valid_i && in_ready_o;
    assign frame_done = accept && (cnt == dong_pkg::CNT_W'(dong_pkg::FRAME_LEN - 1));

    // =========================================================
    // Sequencing
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state   <= S_FILL;
            cnt     <= '0;
            out_len <= dong_pkg::CNT_W'(dong_pkg::FRAME_LEN);
            hb_dec  <= 1'b0;
            wb_mode <= 1'b0;
        end else begin
            case (state)
                S_FILL: begin
                    if (accept) begin
                        hb_dec  <= hb_decoded_i;
                        wb_mode <= wb_output_i;
                        cnt     <= frame_done ? '0 : cnt + 1'b1;
                    end
                    if (frame_done) begin
                        state <= S_TOTAL;
                    end
                end
                S_TOTAL: state <= S_SQRT;
                S_SQRT: begin
                    if (sq_cnt == dong_pkg::SQRT_CNT_W'(dong_pkg::ROOT_W - 1)) begin
                        state <= S_GAIN;
                    end
                end
                S_GAIN: begin
                    out_len <= wb_mode ? dong_pkg::CNT_W'(dong_pkg::WB_LEN) : dong_pkg::CNT_W'(dong_pkg::FRAME_LEN);
                    cnt     <= '0;
                    state   <= S_READ;
                end
                S_READ: state <= S_LOAD;
                S_LOAD: state <= S_OUT;
                S_OUT: begin
                    if (out_ready_i) begin
                        if (cnt == out_len - 1'b1) begin
                            cnt   <= '0;
                            state <= S_FILL;
                        end else begin
                            cnt   <= cnt + 1'b1;
                            state <= S_READ;
                        end
                    end
                end
                default: state <= S_FILL;
            endcase
        end
    end

    // =========================================================
    // Frame store: {lb, wb_odd, wb_even} per beat
    logic [dong_pkg::MEM_AW-1:0] rd_addr;
    assign rd_addr = wb_mode ? dong_pkg::MEM_AW'(cnt >> 1) : dong_pkg::MEM_AW'(cnt);

    dong_frame_mem #(
        .WIDTH (dong_pkg::WORD_W),
        .DEPTH (dong_pkg::MEM_DEPTH),
        .AW    (dong_pkg::MEM_AW)
    ) u_mem (
        .clk_i     (clk_i),
        .wr_en_i   (accept),
        .wr_addr_i (dong_pkg::MEM_AW'(cnt)),
        .wr_data_i ({lb_i, wb_odd_i, wb_even_i}),
        .rd_addr_i (rd_addr),
        .rd_data_o (rd_word)
    );

    // =========================================================
    // High-pass, energy and band powers
    logic signed [dong_pkg::HP_W-1:0]  hp4;
    logic signed [dong_pkg::SQ_W-1:0]  hp_sq;
    logic signed [16:0]                lb_ext;
    logic signed [16:0]                hb_ext;
    logic [16:0]                       lb_abs;
    logic [16:0]                       hb_abs;

    // 4z = 4x(n) - 3x(n-1), exact
    assign hp4 = (dong_pkg::HP_W'(signed'(lb_i)) <<< dong_pkg::HP_CUR_SH)
               - dong_pkg::HP_W'(signed'(prev_lb)) * dong_pkg::HP_W'(dong_pkg::HP_PREV_MUL);
    assign hp_sq  = dong_pkg::SQ_W'(hp4) * dong_pkg::SQ_W'(hp4);
    assign lb_ext = 17'(signed'(lb_i));
    assign hb_ext = 17'(signed'(hb_i));
    assign lb_abs = lb_ext[16] ? unsigned'(-lb_ext) : unsigned'(lb_ext);
    assign hb_abs = hb_ext[16] ? unsigned'(-hb_ext) : unsigned'(hb_ext);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_lb         <= '0;
            frame_energy    <= '0;
            low_band_power  <= '0;
            high_band_power <= '0;
        end else if (accept) begin
            prev_lb         <= signed'(lb_i);
            frame_energy    <= frame_energy + dong_pkg::EN_W'(unsigned'(hp_sq));
            low_band_power  <= low_band_power + dong_pkg::PWR_W'(lb_abs);
            high_band_power <= high_band_power + dong_pkg::PWR_W'(hb_abs);
        end else if (state == S_GAIN) begin
            frame_energy    <= '0;
            low_band_power  <= '0;
            high_band_power <= '0;
        end
    end

    // =========================================================
    // Bit-serial square root, one result bit per cycle
    logic [dong_pkg::REM_W-1:0] sq_shift;
    logic [dong_pkg::REM_W-1:0] sq_trial;
    assign sq_shift = {sq_rem[dong_pkg::REM_W-3:0], radicand[dong_pkg::EN_W-1 -: 2]};
    assign sq_trial = {sq_root, 2'b01};

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            radicand <= '0;
            sq_rem   <= '0;
            sq_root  <= '0;
            sq_cnt   <= '0;
        end else if (state == S_TOTAL) begin
            radicand <= frame_energy + prev_energy;
            sq_rem   <= '0;
            sq_root  <= '0;
            sq_cnt   <= '0;
        end else if (state == S_SQRT) begin
            radicand <= radicand << 2;
            sq_cnt   <= sq_cnt + 1'b1;
            if (sq_shift >= sq_trial) begin
                sq_rem  <= sq_shift - sq_trial;
                sq_root <= {sq_root[dong_pkg::ROOT_W-2:0], 1'b1};
            end else begin
                sq_rem  <= sq_shift;
                sq_root <= {sq_root[dong_pkg::ROOT_W-2:0], 1'b0};
            end
        end
    end

    // =========================================================
    // Target gain and energy history
    logic [dong_pkg::PROD_W-1:0] root_gain;
    logic [dong_pkg::GAIN_W-1:0] energy_gain;
    logic                        hb_above_floor;
    logic                        hb_dominant;

    assign root_gain   = dong_pkg::PROD_W'(sq_root) << dong_pkg::GAIN_SQRT_SH;
    assign energy_gain = (root_gain > dong_pkg::PROD_W'(dong_pkg::GAIN_MAX)) ? dong_pkg::GAIN_MAX :
                         (root_gain < dong_pkg::PROD_W'(dong_pkg::GAIN_QUARTER)) ? dong_pkg::GAIN_QUARTER :
                         root_gain[dong_pkg::GAIN_W-1:0];
    // Threshold compared in cross-multiplied form to avoid a divider
    assign hb_above_floor = (dong_pkg::PROD_W'(high_band_power) * dong_pkg::PROD_W'(dong_pkg::HB_PWR_DEN))
                          > (dong_pkg::PROD_W'(dong_pkg::HB_PWR_NUM) << dong_pkg::HB_PWR_Q);
    assign hb_dominant    = dong_pkg::PROD_W'(high_band_power)
                          > (dong_pkg::PROD_W'(low_band_power) << dong_pkg::HB_RATIO_SH);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_energy <= dong_pkg::ENERGY_RST;
            target_gain <= dong_pkg::GAIN_ONE;
        end else if (state == S_GAIN) begin
            prev_energy <= frame_energy;
            if (hb_dec && hb_above_floor && hb_dominant) begin
                target_gain <= dong_pkg::GAIN_ONE;
            end else begin
                target_gain <= energy_gain;
            end
        end
    end

    // =========================================================
    // Smoothed gain, one step per output sample
    logic [dong_pkg::PROD_W-1:0] gain_mix;
    assign gain_mix = dong_pkg::PROD_W'(smoothed_gate_gain) * dong_pkg::PROD_W'(dong_pkg::COEF_KEEP)
                    + dong_pkg::PROD_W'(target_gain) * dong_pkg::PROD_W'(dong_pkg::COEF_TARGET);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            smoothed_gate_gain <= dong_pkg::GAIN_ONE;
        end else if (state == S_READ) begin
            smoothed_gate_gain <= dong_pkg::GAIN_W'(gain_mix >> dong_pkg::GAIN_FRAC);
        end
    end

    // =========================================================
    // Output scaling
    logic signed [15:0] raw_sample;
    logic signed [32:0] scaled;
    assign raw_sample = !wb_mode ? signed'(rd_word[47:32]) : (cnt[0] ? signed'(rd_word[31:16]) : signed'(rd_word[15:0]));
    assign scaled     = 33'(raw_sample) * 33'(signed'({1'b0, smoothed_gate_gain[15:0]}));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            out_sample_o <= '0;
            out_last_o   <= 1'b0;
        end else if (state == S_LOAD) begin
            out_last_o <= (cnt == out_len - 1'b1);
            if (smoothed_gate_gain < dong_pkg::GAIN_ONE) begin
                out_sample_o <= 16'(scaled >>> dong_pkg::GAIN_FRAC);
            end else begin
                out_sample_o <= raw_sample;
            end
        end
    end

    assign out_valid_o = (state == S_OUT);

    // =========================================================
    // Checks
    sequence s_analysis;
        (state == S_TOTAL) ##1 (state == S_SQRT);
    endsequence

    sequence s_sample_fetch;
        (state == S_READ) ##1 (state == S_LOAD);
    endsequence

    AST_HP_HISTORY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        accept |=> prev_lb == $past(signed'(lb_i)))
        else $error("low-band history not carried");

    AST_ENERGY_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == S_GAIN) |=> frame_energy == '0 && low_band_power == '0)
        else $error("frame accumulators not cleared");

    AST_TOTAL_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_analysis |-> radicand == $past(frame_energy) + $past(prev_energy))
        else $error("total energy wrong");

    AST_HISTORY_UPDATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == S_GAIN) |=> prev_energy == $past(frame_energy))
        else $error("previous energy not replaced");

    AST_TARGET_FLOOR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == S_READ) |-> target_gain >= dong_pkg::GAIN_QUARTER)
        else $error("target gain under 0.25");

    AST_NB_NO_OVERRIDE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == S_GAIN && !hb_dec) |=> target_gain == $past(energy_gain))
        else $error("narrow-band target overridden");

    AST_HB_OPEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == S_GAIN && hb_dec && hb_above_floor && hb_dominant) |=> target_gain == dong_pkg::GAIN_ONE)
        else $error("gate not opened");

    AST_GAIN_TOWARD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_sample_fetch |-> (($past(smoothed_gate_gain) >= target_gain) ? smoothed_gate_gain <= $past(smoothed_gate_gain)
                                                                        : smoothed_gate_gain >= $past(smoothed_gate_gain)))
        else $error("smoothed gain moved away from target");

    AST_GAIN_RESET: assert property (@(posedge clk_i)
        !rst_n_i |=> smoothed_gate_gain == dong_pkg::GAIN_ONE)
        else $error("gain not 1.0 after reset");

    AST_PASS_THROUGH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == S_LOAD && smoothed_gate_gain >= dong_pkg::GAIN_ONE) |=> out_sample_o == $past(raw_sample))
        else $error("unity gain sample altered");

    AST_NO_EARLY_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        frame_done |=> !out_valid_o [*8])
        else $error("output before analysis");
endmodule // dong_noise_gate

// >>> verification/dong_stream_partner.sv
// Far-side model: frame source ahead of the gate and an audio sink that can stall
`timescale 1ns/1ns
module dong_stream_partner (
    input  logic        clk_i,
    input  logic        rst_n_i,
    input  logic        go_i,
    input  logic        slow_i,
    input  logic        hb_dec_i,
    input  logic        wb_out_i,
    input  logic [15:0] lb_frame_i [40],
    input  logic [15:0] hb_frame_i [40],
    input  logic [15:0] wb_frame_i [80],
    input  logic        in_ready_i,
    input  logic        out_valid_i,
    input  logic [15:0] out_sample_i,
    input  logic        out_last_i,
    output logic        in_valid_o,
    output logic [15:0] lb_o,
    output logic [15:0] hb_o,
    output logic [15:0] wb_even_o,
    output logic [15:0] wb_odd_o,
    output logic        hb_decoded_o,
    output logic        wb_output_o,
    output logic        out_ready_o,
    output logic [15:0] cap_o [80],
    output int          cap_n_o,
    output int          last_at_o,
    output logic        overlap_o
);
    int          beat;
    logic [1:0]  stall;
    logic [63:0] held;
    // =========================================================
    // Source
    // beat held until taken
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            in_valid_o <= 1'b0;
            beat       <= 0;
            held       <= 64'h0;
        end else if (go_i) begin
            in_valid_o <= 1'b1;
            beat       <= 0;
        end else if (in_valid_o && in_ready_i) begin
            held <= {lb_o, hb_o, wb_even_o, wb_odd_o};
            beat <= beat + 1;
            if (beat == 39) begin
                in_valid_o <= 1'b0;
            end
        end
    end
    // Released lines show the inverse of the last beat so stale data never looks valid
    assign lb_o         = in_valid_o ? lb_frame_i[beat % 40] : ~held[63:48];
    assign hb_o         = in_valid_o ? hb_frame_i[beat % 40] : ~held[47:32];
    assign wb_even_o    = in_valid_o ? wb_frame_i[2 * (beat % 40)] : ~held[31:16];
    assign wb_odd_o     = in_valid_o ? wb_frame_i[2 * (beat % 40) + 1] : ~held[15:0];
    assign hb_decoded_o = in_valid_o ? hb_dec_i : ~hb_dec_i;
    assign wb_output_o  = in_valid_o ? wb_out_i : ~wb_out_i;
    // =========================================================
    // Sink
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stall <= 2'h0;
        end else begin
            stall <= stall + 2'h1;
        end
    end
    assign out_ready_o = !slow_i || (stall == 2'h3);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || go_i) begin
            cap_n_o   <= 0;
            last_at_o <= -1;
            overlap_o <= 1'b0;
        end else begin
            if (out_valid_i && in_ready_i) begin
                overlap_o <= 1'b1;
            end
            if (out_valid_i && out_ready_o) begin
                cap_o[cap_n_o % 80] <= out_sample_i;
                cap_n_o             <= cap_n_o + 1;
                if (out_last_i) begin
                    last_at_o <= cap_n_o;
                end
            end
        end
    end
endmodule // dong_stream_partner

// >>> verification/tb_decoder_output_noise_gate.sv
// Self-checking bench for the decoder output noise gate
`timescale 1ns/1ns
module tb_decoder_output_noise_gate;
    logic        clk_i;
    logic        rst_n_i;
    logic        go;
    logic        slow;
    logic        hb_dec;
    logic        wb_out;
    logic [15:0] lb_f [40];
    logic [15:0] hb_f [40];
    logic [15:0] wb_f [80];
    logic [15:0] cap [80];
    logic        in_valid, in_ready, hb_decoded, wb_output, out_valid, out_ready, out_last, overlap;
    logic [15:0] lb, hb, wb_even, wb_odd, out_sample;
    int          cap_n, last_at;
    int          bad_count;
    int          comparisons;
    int          cycles = 0;
    longint      g_m, e_prev;
    logic [15:0] x_prev;

    dong_noise_gate dong_noise_gate_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .in_valid_i(in_valid),
        .in_ready_o(in_ready), .lb_i(lb), .hb_i(hb), .wb_even_i(wb_even), .wb_odd_i(wb_odd),
        .hb_decoded_i(hb_decoded), .wb_output_i(wb_output), .out_valid_o(out_valid),
        .out_ready_i(out_ready), .out_sample_o(out_sample), .out_last_o(out_last));
    dong_stream_partner dong_stream_partner_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .slow_i(slow),
        .hb_dec_i(hb_dec), .wb_out_i(wb_out), .lb_frame_i(lb_f), .hb_frame_i(hb_f), .wb_frame_i(wb_f),
        .in_ready_i(in_ready), .out_valid_i(out_valid), .out_sample_i(out_sample), .out_last_i(out_last),
        .in_valid_o(in_valid), .lb_o(lb), .hb_o(hb), .wb_even_o(wb_even), .wb_odd_o(wb_odd),
        .hb_decoded_o(hb_decoded), .wb_output_o(wb_output), .out_ready_o(out_ready), .cap_o(cap),
        .cap_n_o(cap_n), .last_at_o(last_at), .overlap_o(overlap));
    // =========================================================
    // Helpers
    function automatic longint absv(input logic [15:0] v);
        return ($signed(v) < 0) ? -longint'($signed(v)) : longint'($signed(v));
    endfunction
    function automatic longint isqrt(input longint v);
        longint r;
        r = 0;
        for (int b = 23; b >= 0; b--) begin
            if ((r + (64'sd1 << b)) * (r + (64'sd1 << b)) <= v) r = r + (64'sd1 << b);
        end
        return r;
    endfunction
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Reference model keeps its own energy, history and gain state across frames
    task automatic send_frame(input logic hbd, input logic wbo, input logic slw);
        longint      e0, gt, plb, phb, p;
        logic [15:0] s;
        logic [15:0] exp_s [80];
        int          n;
        e0 = 0;
        plb = 0;
        phb = 0;
        for (int k = 0; k < 40; k++) begin
            p = 4 * longint'($signed(lb_f[k])) - 3 * longint'($signed(k == 0 ? x_prev : lb_f[(k + 39) % 40]));
            e0 += p * p;
            plb += absv(lb_f[k]);
            phb += absv(hb_f[k]);
        end
        gt = isqrt(e0 + e_prev) * 64;
        if (gt < dong_pkg::GAIN_QUARTER) gt = dong_pkg::GAIN_QUARTER;
        if (gt > dong_pkg::GAIN_MAX) gt = dong_pkg::GAIN_MAX;
        if (hbd && phb > 0 && phb > 16 * plb) gt = dong_pkg::GAIN_ONE;
        e_prev = e0;
        x_prev = lb_f[39];
        n = wbo ? 80 : 40;
        for (int k = 0; k < n; k++) begin
            s = wbo ? wb_f[k] : lb_f[k];
            g_m = (g_m * dong_pkg::COEF_KEEP + gt * dong_pkg::COEF_TARGET) >> 15;
            p = (longint'($signed(s)) * g_m) >>> 15;
            exp_s[k] = (g_m < 32768) ? p[15:0] : s;
        end
        @(posedge clk_i);
        go <= 1'b1;
        slow <= slw;
        hb_dec <= hbd;
        wb_out <= wbo;
        @(posedge clk_i);
        go <= 1'b0;
        // Look at falling edges so the partner's restart of its capture count has landed
        @(negedge clk_i);
        for (int w = 0; w < 3000 && !(cap_n == n && in_ready === 1'b1); w++) @(negedge clk_i);
        check_val("sample count", 16'(n), 16'(cap_n));
        check_val("last index", 16'(n - 1), 16'(last_at));
        check_val("output during fill", 16'h0000, {15'h0, overlap});
        for (int k = 0; k < n; k++) begin
            check_val("gated sample", exp_s[k], cap[k]);
        end
    endtask
    // =========================================================
    // Scenarios
    task automatic test_after_reset();
        @(negedge clk_i);
        check_val("in_ready after reset", 16'h0001, {15'h0, in_ready});
        check_val("out_valid after reset", 16'h0000, {15'h0, out_valid});
        check_val("out_sample after reset", 16'h0000, out_sample);
        check_val("out_last after reset", 16'h0000, {15'h0, out_last});
        $display("test_after_reset finished");
    endtask
    task automatic test_quiet_nb();
        for (int k = 0; k < 80; k++) wb_f[k] = 16'(k * 37 - 1500);
        for (int k = 0; k < 40; k++) lb_f[k] = 16'((k % 4) * 3 - 4);
        send_frame(1'b0, 1'b0, 1'b0);
        for (int k = 0; k < 40; k++) lb_f[k] = 16'((k % 7) * 40 - 100);
        send_frame(1'b0, 1'b0, 1'b0);
        $display("test_quiet_nb finished");
    endtask
    task automatic test_hb_gate();
        int amps [3] = '{17, 16, 17};
        logic decs [3] = '{1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 40; k++) begin
                lb_f[k] = (k % 2) ? 16'h0001 : 16'hffff;
                hb_f[k] = 16'((k % 2) ? amps[i] : -amps[i]);
            end
            send_frame(decs[i], 1'b1, 1'b0);
        end
        $display("test_hb_gate finished");
    endtask
    task automatic test_loud_wb();
        for (int k = 0; k < 80; k++) wb_f[k] = 16'(k * 400 - 16000);
        for (int k = 0; k < 40; k++) lb_f[k] = (k % 2) ? 16'h4e20 : 16'hb1e0;
        send_frame(1'b0, 1'b1, 1'b1);
        send_frame(1'b0, 1'b1, 1'b1);
        $display("test_loud_wb finished");
    endtask
    // =========================================================
    // Run
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        go = 1'b0;
        slow = 1'b0;
        hb_dec = 1'b0;
        wb_out = 1'b0;
        g_m = 32768;
        e_prev = 0;
        x_prev = 16'h0000;
        bad_count = 0;
        comparisons = 0;
        for (int k = 0; k < 80; k++) wb_f[k] = 16'h0000;
        for (int k = 0; k < 40; k++) lb_f[k] = 16'h0000;
        for (int k = 0; k < 40; k++) hb_f[k] = 16'h0000;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        test_after_reset();
        test_quiet_nb();
        test_hb_gate();
        test_loud_wb();
        complete_run();
    end
endmodule // tb_decoder_output_noise_gate
